// ===== rtl/apcu_axis_position_compare_unit.sv
// axis position counters, compare/limit logic, ring wrap and z-phase clear
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps

// What this block does
// RULE1 - logical counter steps up or down with each drive pulse direction
// RULE2 - real counter counts encoder quadrature or separate up/down pulses
// RULE3 - both counters are signed 32-bit two's complement
// RULE4 - host reads or overwrites either counter any time, even driving
// RULE5 - one config bit picks logical or real counter for comparing
// RULE6 - selected counter above upper compare sets upper compare flag
// RULE7 - selected counter below lower compare sets lower compare flag
// RULE8 - two config bits enable software limits using the compare registers
// RULE9 - upper limit passed while driving causes decelerating stop and error flag
// RULE10 - positive limit error clears itself once counter is back in range
// RULE11 - host may write both compare registers at any time
// RULE12 - by default counters wrap through the full 32-bit range
// RULE13 - ring enable makes upper compare the logical top, lower the real top
// RULE14 - in ring mode counters wrap between zero and their programmed top
// RULE15 - one ring enable serves both counters of the axis together
// RULE16 - software limits are disabled while ring mode is on
// RULE17 - encoder clear enable clears real counter on z-phase active rising edge
// RULE18 - z-phase input needs an enable bit and a selectable active level
// RULE19 - z-phase search stops drive pulses at once on detection
// RULE20 - drive speed below initial speed means constant speed driving
// RULE21 - only the z-phase input may clear the real counter
// RULE22 - outside source holds z-phase active longer than four external clocks
// RULE23 - z-phase already active when clear is enabled still clears counter
// RULE24 - compare and limit checks are re-evaluated every internal clock tick
module apcu_axis_position_compare_unit
  import apcu_pkg::*;
#(
  parameter int unsigned CNT_W = 32,
  parameter int unsigned PER_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // encoder and general inputs
  input wire logic enc_phase_a,
  input wire logic enc_phase_b,
  input wire logic zphase_input,
  input wire logic general_input_a,
  input wire logic general_input_b,
  input wire logic general_input_d,
  // drive outputs
  output logic drive_pos_pulse,
  output logic drive_neg_pulse,
  output logic drive_busy
);

  generate
    if (CNT_W != 32 || PER_W < 2 || PER_W > 16) begin : g_bad_param
      $error("apcu: counters must be 32 bits and period width 2..16");
    end
  endgenerate

  localparam logic [31:0] FULL_TOP = 32'hffffffff;

  // synchronisers: enc a, enc b, z, gen a, gen b, gen d
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic [5:0] pin_prev_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 6'h00;
      pin_sync_reg <= 6'h00;
      pin_prev_reg <= 6'h00;
    end else begin
      pin_meta_reg <= {general_input_d, general_input_b, general_input_a,
                       zphase_input, enc_phase_b, enc_phase_a};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // internal tick at half the system clock
  logic sclk_en_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclk_en_reg <= 1'b0;
    end else begin
      sclk_en_reg <= ~sclk_en_reg;
    end
  end

  // registers
  logic [31:0] logic_pos_reg;
  logic [31:0] real_pos_reg;
  logic [31:0] cmp_upper_reg;
  logic [31:0] cmp_lower_reg;
  logic [31:0] wdata_low_reg;
  logic [PER_W-1:0] init_per_reg;
  logic [PER_W-1:0] drive_per_reg;
  apcu_incfg_s input_config_reg;
  apcu_limcfg_s limit_config_reg;
  apcu_ext_s ext_mode_reg;
  logic upper_compare_flag;
  logic lower_compare_flag;
  logic positive_soft_limit_error;
  logic negative_soft_limit_error;

  // apb decode
  logic wr_acc;
  logic addr_hit;
  logic cmd_wr;
  logic [7:0] cmd_code;

  assign wr_acc = psel & penable & pwrite;
  assign cmd_wr = wr_acc & (paddr == OFS_COMMAND);
  assign cmd_code = pwdata[7:0];

  always_comb begin
    unique case (paddr)
      OFS_LOGIC_POS, OFS_REAL_POS, OFS_CMP_UPPER, OFS_CMP_LOWER,
      OFS_INPUT_CFG, OFS_LIMIT_CFG, OFS_WDATA_LOW, OFS_COMMAND,
      OFS_CMP_STATUS, OFS_ERR_STATUS, OFS_INIT_PER, OFS_DRIVE_PER,
      OFS_DRV_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // zero wait state; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // configuration writes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmp_upper_reg <= RST_WORD;
      cmp_lower_reg <= RST_WORD;
      wdata_low_reg <= RST_WORD;
      input_config_reg <= '0;
      limit_config_reg <= '0;
      ext_mode_reg <= '0;
      init_per_reg <= RST_INIT_PER[PER_W-1:0];
      drive_per_reg <= RST_DRIVE_PER[PER_W-1:0];
    end else if (wr_acc) begin
      unique case (paddr)
        OFS_CMP_UPPER: cmp_upper_reg <= pwdata; // RULE11
        OFS_CMP_LOWER: cmp_lower_reg <= pwdata; // RULE11
        OFS_WDATA_LOW: wdata_low_reg <= pwdata;
        OFS_INPUT_CFG: input_config_reg <= {pwdata[INCFG_ZEN_BIT],
                                            pwdata[INCFG_ZLVL_BIT],
                                            pwdata[INCFG_ENC_UPDN_BIT]}; // RULE18
        OFS_LIMIT_CFG: limit_config_reg <= {pwdata[LIM_SRC_BIT],
                                            pwdata[LIM_NEG_EN_BIT],
                                            pwdata[LIM_POS_EN_BIT]}; // RULE5 RULE8
        OFS_INIT_PER: init_per_reg <= pwdata[PER_W-1:0];
        OFS_DRIVE_PER: drive_per_reg <= pwdata[PER_W-1:0];
        OFS_COMMAND: begin
          if (cmd_code == CMD_EXT_MODE) begin
            // one enable for both counters
            ext_mode_reg <= {wdata_low_reg[EXT_VWRAP_BIT],
                             wdata_low_reg[EXT_CLR_BIT]}; // RULE15
          end
        end
        default: ;
      endcase
    end
  end

  // encoder decode
  logic enc_up;
  logic enc_dn;
  logic quad_move;

  assign quad_move = (pin_sync_reg[0] ^ pin_prev_reg[0]) ^
                     (pin_sync_reg[1] ^ pin_prev_reg[1]);

  always_comb begin
    if (input_config_reg.enc_updn) begin
      enc_up = pin_sync_reg[0] & ~pin_prev_reg[0]; // RULE2
      enc_dn = pin_sync_reg[1] & ~pin_prev_reg[1]; // RULE2
    end else begin
      // a single phase change per sample; a double change is a lost step
      enc_up = quad_move & (pin_sync_reg[0] ^ pin_prev_reg[1]); // RULE2
      enc_dn = quad_move & ~(pin_sync_reg[0] ^ pin_prev_reg[1]); // RULE2
    end
  end

  // z-phase detection on the synchronised level only
  logic z_act_now;
  logic z_act_prev;
  logic z_rise;
  logic z_clr_ext;
  logic real_clr;

  assign z_act_now = input_config_reg.z_en &
                     (pin_sync_reg[2] == input_config_reg.z_lvl); // RULE18
  assign z_act_prev = input_config_reg.z_en &
                      (pin_prev_reg[2] == input_config_reg.z_lvl);
  assign z_rise = z_act_now & ~z_act_prev;
  assign z_clr_ext = cmd_wr & (cmd_code == CMD_EXT_MODE) &
                     wdata_low_reg[EXT_CLR_BIT] & z_act_now; // RULE23
  // general inputs a, b and d are status only
  assign real_clr = (ext_mode_reg.clr_en & z_rise) | z_clr_ext; // RULE17 RULE21

  // ring step: full range unless ring mode supplies a top
  function automatic logic [31:0] ring_step(input logic [31:0] cnt,
                                            input logic [31:0] top,
                                            input logic up);
    if (up) begin
      ring_step = (cnt == top) ? 32'h0 : cnt + 32'h1; // RULE12 RULE14
    end else begin
      ring_step = (cnt == 32'h0) ? top : cnt - 32'h1; // RULE12 RULE14
    end
  endfunction

  logic [31:0] logic_top;
  logic [31:0] real_top;

  assign logic_top = ext_mode_reg.vwrap_en ? cmp_upper_reg : FULL_TOP; // RULE13
  assign real_top = ext_mode_reg.vwrap_en ? cmp_lower_reg : FULL_TOP; // RULE13

  // drive engine
  apcu_drv_e drv_state_reg;
  logic drv_dir_pos_reg;
  logic zsearch_reg;
  logic [PER_W-1:0] cur_per_reg;
  logic [PER_W-1:0] tick_cnt_reg;
  logic [PER_W-1:0] ramp_top;
  logic const_speed;
  logic step_now;
  logic limit_hit;
  logic start_cmd;

  assign const_speed = drive_per_reg > init_per_reg; // RULE20
  assign ramp_top = const_speed ? drive_per_reg : init_per_reg;
  assign step_now = sclk_en_reg & (drv_state_reg != DRV_IDLE) &
                    (tick_cnt_reg == '0);
  assign limit_hit = drv_dir_pos_reg ? positive_soft_limit_error
                                     : negative_soft_limit_error;
  assign start_cmd = cmd_wr & ((cmd_code == CMD_DRV_POS) |
                     (cmd_code == CMD_DRV_NEG) | (cmd_code == CMD_ZSRCH_POS) |
                     (cmd_code == CMD_ZSRCH_NEG));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drv_state_reg <= DRV_IDLE;
      drv_dir_pos_reg <= 1'b1;
      zsearch_reg <= 1'b0;
      cur_per_reg <= RST_INIT_PER[PER_W-1:0];
      tick_cnt_reg <= '0;
    end else if ((cmd_wr & (cmd_code == CMD_HARD_STOP)) |
                 (zsearch_reg & z_act_now)) begin
      drv_state_reg <= DRV_IDLE; // RULE19
      zsearch_reg <= 1'b0;
      tick_cnt_reg <= '0;
    end else if (start_cmd & (drv_state_reg == DRV_IDLE)) begin
      drv_state_reg <= DRV_RUN;
      drv_dir_pos_reg <= ~cmd_code[0];
      zsearch_reg <= cmd_code[1];
      cur_per_reg <= ramp_top; // RULE20
      tick_cnt_reg <= '0;
    end else begin
      if ((drv_state_reg == DRV_RUN) &
          ((cmd_wr & (cmd_code == CMD_DECEL_STOP)) | limit_hit)) begin
        drv_state_reg <= DRV_DECEL; // RULE9
      end
      if (sclk_en_reg & (drv_state_reg != DRV_IDLE)) begin
        if (tick_cnt_reg == '0) begin
          tick_cnt_reg <= cur_per_reg - 1'b1;
          unique case (drv_state_reg)
            DRV_RUN: begin
              if (cur_per_reg > drive_per_reg) begin
                cur_per_reg <= cur_per_reg - 1'b1;
              end
            end
            DRV_DECEL: begin
              // ramp back to the start period, then stop
              if (cur_per_reg >= ramp_top) begin
                drv_state_reg <= DRV_IDLE; // RULE9
                zsearch_reg <= 1'b0;
              end else begin
                cur_per_reg <= cur_per_reg + 1'b1;
              end
            end
            default: ;
          endcase
        end else begin
          tick_cnt_reg <= tick_cnt_reg - 1'b1;
        end
      end
    end
  end

  // pulse outputs: high for the first half of each period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_pos_pulse <= 1'b0;
      drive_neg_pulse <= 1'b0;
      drive_busy <= 1'b0;
    end else begin
      drive_busy <= drv_state_reg != DRV_IDLE;
      if (step_now) begin
        drive_pos_pulse <= drv_dir_pos_reg;
        drive_neg_pulse <= ~drv_dir_pos_reg;
      end else if ((drv_state_reg == DRV_IDLE) |
                   (tick_cnt_reg <= (cur_per_reg >> 1))) begin
        drive_pos_pulse <= 1'b0;
        drive_neg_pulse <= 1'b0;
      end
    end
  end

  // position counters; host write wins over counting
  logic lpos_wr;
  logic rpos_wr;

  assign lpos_wr = wr_acc & (paddr == OFS_LOGIC_POS);
  assign rpos_wr = wr_acc & (paddr == OFS_REAL_POS);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      logic_pos_reg <= RST_WORD; // RULE3
    end else if (lpos_wr) begin
      logic_pos_reg <= pwdata; // RULE4
    end else if (step_now) begin
      logic_pos_reg <= ring_step(logic_pos_reg, logic_top,
                                 drv_dir_pos_reg); // RULE1
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      real_pos_reg <= RST_WORD; // RULE3
    end else if (rpos_wr) begin
      real_pos_reg <= pwdata; // RULE4
    end else if (real_clr) begin
      real_pos_reg <= 32'h0; // RULE17 RULE23
    end else if (enc_up) begin
      real_pos_reg <= ring_step(real_pos_reg, real_top, 1'b1); // RULE2
    end else if (enc_dn) begin
      real_pos_reg <= ring_step(real_pos_reg, real_top, 1'b0); // RULE2
    end
  end

  // compare and soft limit
  logic [31:0] sel_pos;
  logic above_upper;
  logic below_lower;

  assign sel_pos = limit_config_reg.src_real ? real_pos_reg : logic_pos_reg; // RULE5
  assign above_upper = $signed(sel_pos) > $signed(cmp_upper_reg);
  assign below_lower = $signed(sel_pos) < $signed(cmp_lower_reg);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      upper_compare_flag <= 1'b0;
      lower_compare_flag <= 1'b0;
      positive_soft_limit_error <= 1'b0;
      negative_soft_limit_error <= 1'b0;
    end else if (sclk_en_reg) begin // RULE24
      upper_compare_flag <= above_upper; // RULE6
      lower_compare_flag <= below_lower; // RULE7
      // limits make no sense on a ring, so ring mode masks them
      positive_soft_limit_error <= limit_config_reg.pos_en &
                                   ~ext_mode_reg.vwrap_en & above_upper; // RULE8 RULE10 RULE16
      negative_soft_limit_error <= limit_config_reg.neg_en &
                                   ~ext_mode_reg.vwrap_en & below_lower; // RULE8 RULE16
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= RST_WORD;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        OFS_LOGIC_POS: prdata <= logic_pos_reg; // RULE4
        OFS_REAL_POS: prdata <= real_pos_reg; // RULE4
        OFS_CMP_UPPER: prdata <= cmp_upper_reg;
        OFS_CMP_LOWER: prdata <= cmp_lower_reg;
        OFS_INPUT_CFG: prdata <= {26'h0, input_config_reg.z_en,
                                  input_config_reg.z_lvl, 3'h0,
                                  input_config_reg.enc_updn};
        OFS_LIMIT_CFG: prdata <= {26'h0, limit_config_reg.src_real, 3'h0,
                                  limit_config_reg.neg_en,
                                  limit_config_reg.pos_en};
        OFS_WDATA_LOW: prdata <= wdata_low_reg;
        OFS_CMP_STATUS: prdata <= {30'h0, lower_compare_flag,
                                   upper_compare_flag};
        OFS_ERR_STATUS: prdata <= {30'h0, negative_soft_limit_error,
                                   positive_soft_limit_error};
        OFS_INIT_PER: prdata <= {{(32-PER_W){1'b0}}, init_per_reg};
        OFS_DRIVE_PER: prdata <= {{(32-PER_W){1'b0}}, drive_per_reg};
        OFS_DRV_STATUS: prdata <= {20'h0, pin_sync_reg[5:2], 2'h0,
                                   ext_mode_reg.vwrap_en, ext_mode_reg.clr_en,
                                   zsearch_reg, drv_dir_pos_reg,
                                   drv_state_reg};
        default: prdata <= RST_WORD;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_fwd_step;
    step_now && drv_dir_pos_reg && !lpos_wr && !ext_mode_reg.vwrap_en;
  endsequence

  sequence s_rev_step;
    step_now && !drv_dir_pos_reg && !lpos_wr && !ext_mode_reg.vwrap_en;
  endsequence

  sequence s_z_hit;
    zsearch_reg && drv_state_reg != DRV_IDLE && z_act_now && !start_cmd;
  endsequence

  AST_LOGIC_UP: assert property (s_fwd_step |=> // RULE1
    logic_pos_reg == $past(logic_pos_reg) + 32'h1)
    else $error("logical counter did not count up");

  AST_LOGIC_DN: assert property (s_rev_step |=> // RULE1
    logic_pos_reg == $past(logic_pos_reg) - 32'h1)
    else $error("logical counter did not count down");

  AST_HOST_WR: assert property (lpos_wr |=> // RULE4
    logic_pos_reg == $past(pwdata))
    else $error("host write to logical counter lost");

  AST_UPPER_FLAG: assert property (sclk_en_reg && above_upper |=> // RULE6
    upper_compare_flag [*2])
    else $error("upper compare flag not set");

  AST_LOWER_FLAG: assert property (sclk_en_reg && below_lower && // RULE7
    $stable(sel_pos) |=> lower_compare_flag)
    else $error("lower compare flag not set");

  AST_SOFT_CLR: assert property (sclk_en_reg && !above_upper |=> // RULE10
    !positive_soft_limit_error)
    else $error("positive limit error did not clear");

  AST_RING_MASK: assert property (sclk_en_reg && ext_mode_reg.vwrap_en // RULE16
    |=> !positive_soft_limit_error && !negative_soft_limit_error)
    else $error("soft limit active in ring mode");

  AST_RING_WRAP: assert property (step_now && drv_dir_pos_reg && !lpos_wr && // RULE14
    ext_mode_reg.vwrap_en && logic_pos_reg == cmp_upper_reg |=>
    logic_pos_reg == 32'h0)
    else $error("ring wrap to zero missed");

  AST_Z_CLEAR: assert property (real_clr && !rpos_wr |=> // RULE17
    real_pos_reg == 32'h0)
    else $error("real counter not cleared by z-phase");

  AST_Z_STOP: assert property (s_z_hit |=> // RULE19
    drv_state_reg == DRV_IDLE ##1 !drive_pos_pulse && !drive_neg_pulse)
    else $error("drive did not stop on z-phase");

  AST_SLOW_CONST: assert property (start_cmd && drv_state_reg == DRV_IDLE && // RULE20
    const_speed |=> cur_per_reg == $past(drive_per_reg))
    else $error("constant speed start period wrong");

endmodule // apcu_axis_position_compare_unit

// ===== rtl/apcu_pkg.sv
// shared constants and types for the axis position compare unit
package apcu_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_LOGIC_POS = 8'h00;
  localparam logic [7:0] OFS_REAL_POS = 8'h04;
  localparam logic [7:0] OFS_CMP_UPPER = 8'h08;
  localparam logic [7:0] OFS_CMP_LOWER = 8'h0c;
  localparam logic [7:0] OFS_INPUT_CFG = 8'h10;
  localparam logic [7:0] OFS_LIMIT_CFG = 8'h14;
  localparam logic [7:0] OFS_WDATA_LOW = 8'h18;
  localparam logic [7:0] OFS_COMMAND = 8'h1c;
  localparam logic [7:0] OFS_CMP_STATUS = 8'h20;
  localparam logic [7:0] OFS_ERR_STATUS = 8'h24;
  localparam logic [7:0] OFS_INIT_PER = 8'h28;
  localparam logic [7:0] OFS_DRIVE_PER = 8'h2c;
  localparam logic [7:0] OFS_DRV_STATUS = 8'h30;

  // command codes
  localparam logic [7:0] CMD_EXT_MODE = 8'h60;
  localparam logic [7:0] CMD_DRV_POS = 8'h20;
  localparam logic [7:0] CMD_DRV_NEG = 8'h21;
  localparam logic [7:0] CMD_ZSRCH_POS = 8'h22;
  localparam logic [7:0] CMD_ZSRCH_NEG = 8'h23;
  localparam logic [7:0] CMD_DECEL_STOP = 8'h26;
  localparam logic [7:0] CMD_HARD_STOP = 8'h27;

  // field positions
  localparam int unsigned INCFG_ENC_UPDN_BIT = 0;
  localparam int unsigned INCFG_ZLVL_BIT = 4;
  localparam int unsigned INCFG_ZEN_BIT = 5;
  localparam int unsigned LIM_POS_EN_BIT = 0;
  localparam int unsigned LIM_NEG_EN_BIT = 1;
  localparam int unsigned LIM_SRC_BIT = 5;
  localparam int unsigned EXT_CLR_BIT = 0;
  localparam int unsigned EXT_VWRAP_BIT = 4;

  // reset values and timing
  localparam logic [15:0] RST_INIT_PER = 16'h0064;
  localparam logic [15:0] RST_DRIVE_PER = 16'h0064;
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam int unsigned SCLK_DIV = 2;

  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_RUN = 2'b01,
    DRV_DECEL = 2'b10
  } apcu_drv_e;

  typedef struct packed {
    logic vwrap_en;
    logic clr_en;
  } apcu_ext_s;

  typedef struct packed {
    logic z_en;
    logic z_lvl;
    logic enc_updn;
  } apcu_incfg_s;

  typedef struct packed {
    logic src_real;
    logic neg_en;
    logic pos_en;
  } apcu_limcfg_s;

endpackage

// ===== testbench/apcu_enc_model.sv
// encoder pulse source and z-phase pin model facing the position compare unit
`timescale 1ns/1ps
module apcu_enc_model (
  // clock
  input wire logic clk_sys,
  // encoder and index lines
  output logic enc_phase_a,
  output logic enc_phase_b,
  output logic zphase_input
);
  initial begin
    enc_phase_a = 1'b0;
    enc_phase_b = 1'b0;
    zphase_input = 1'b0;
  end
  // up/down format, one line per direction, 3 clk high then 3 clk low
  task automatic step(input logic up);
    if (up) enc_phase_a <= 1'b1;
    else enc_phase_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    enc_phase_a <= 1'b0;
    enc_phase_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // quadrature, one full cycle: a leads b counting up, b leads a counting down
  task automatic quad(input logic up);
    repeat (2) begin
      if (up) enc_phase_a <= ~enc_phase_a;
      else enc_phase_b <= ~enc_phase_b;
      repeat (3) @(posedge clk_sys);
      if (up) enc_phase_b <= ~enc_phase_b;
      else enc_phase_a <= ~enc_phase_a;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // each level held six clocks, past the four the synchroniser needs
  task automatic zset(input logic v);
    zphase_input <= v;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // apcu_enc_model

// ===== testbench/tb_axis_position_compare_unit.sv
// self-checking bench for the axis position compare unit
`timescale 1ns/1ps
module tb_axis_position_compare_unit;
  import apcu_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic enc_phase_a, enc_phase_b, zphase_input, drive_pos_pulse, drive_neg_pulse, drive_busy;
  logic [2:0] gin;
  int num_errors = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  apcu_axis_position_compare_unit uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .enc_phase_a, .enc_phase_b, .zphase_input,
    .general_input_a(gin[0]), .general_input_b(gin[1]), .general_input_d(gin[2]),
    .drive_pos_pulse, .drive_neg_pulse, .drive_busy);
  apcu_enc_model enc (.clk_sys, .enc_phase_a, .enc_phase_b, .zphase_input);
  task automatic finish_test;
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      finish_test;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // settle time covers the tick-aligned flag update
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    logic e;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, a, 32'h0, q, e);
    check(nm, exp, q);
  endtask
  // stop long before the next step: period is 40 clk, stop takes 3
  task automatic drive(input logic [7:0] cmd, input int n);
    int k = 0;
    int c = 0;
    logic prev = 1'b0;
    logic cur;
    wr(OFS_COMMAND, {24'h0, cmd});
    while (k < n) begin
      @(posedge clk_sys);
      cur = (cmd == CMD_DRV_NEG) ? drive_neg_pulse : drive_pos_pulse;
      if (cur === 1'b1 && prev !== 1'b1) k++;
      prev = cur;
      c++;
      if (c > 5000) begin
        num_errors++;
        finish_test;
      end
    end
    wr(OFS_COMMAND, {24'h0, CMD_HARD_STOP});
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    wr(OFS_LOGIC_POS, 32'h7fffffff);
    rd(OFS_LOGIC_POS, 32'h7fffffff, "logic_pos");
    wr(OFS_REAL_POS, 32'h80000000);
    rd(OFS_REAL_POS, 32'h80000000, "real_pos");
    wr(OFS_CMP_UPPER, 32'h0000000a);
    rd(OFS_CMP_UPPER, 32'h0000000a, "cmp_upper");
    wr(OFS_CMP_LOWER, 32'hfffffff6);
    rd(OFS_CMP_LOWER, 32'hfffffff6, "cmp_lower");
    apb(1'b0, 8'h40, 32'h0, q, e);
    check("unmapped_err", 32'h1, {31'h0, e});
  endtask
  task automatic t_count;
    wr(OFS_LOGIC_POS, 32'hfffffffe);
    drive(CMD_DRV_POS, 3);
    rd(OFS_LOGIC_POS, 32'h00000001, "logic_up");
    drive(CMD_DRV_NEG, 2);
    rd(OFS_LOGIC_POS, 32'hffffffff, "logic_down");
  endtask
  task automatic t_cmp;
    wr(OFS_LIMIT_CFG, 32'h0);
    wr(OFS_LOGIC_POS, 32'h0000000b);
    rd(OFS_CMP_STATUS, 32'h1, "cmp_above");
    wr(OFS_LOGIC_POS, 32'hfffffff5);
    rd(OFS_CMP_STATUS, 32'h2, "cmp_below");
    wr(OFS_LIMIT_CFG, 32'h20);
    wr(OFS_REAL_POS, 32'h0000000a);
    rd(OFS_CMP_STATUS, 32'h0, "cmp_real_eq");
    wr(OFS_REAL_POS, 32'h0000000b);
    rd(OFS_CMP_STATUS, 32'h1, "cmp_real_above");
  endtask
  task automatic t_enc;
    wr(OFS_INPUT_CFG, 32'h1);
    wr(OFS_REAL_POS, 32'h0);
    for (int i = 0; i < 3; i++) enc.step(1'b1);
    enc.step(1'b0);
    rd(OFS_REAL_POS, 32'h2, "real_count");
    wr(OFS_INPUT_CFG, 32'h0);
    wr(OFS_REAL_POS, 32'h0);
    enc.quad(1'b1);
    enc.quad(1'b1);
    enc.quad(1'b0);
    rd(OFS_REAL_POS, 32'h4, "real_quad");
  endtask
  task automatic t_zclr;
    wr(OFS_INPUT_CFG, 32'h31);
    wr(OFS_WDATA_LOW, 32'h1);
    wr(OFS_COMMAND, {24'h0, CMD_EXT_MODE});
    wr(OFS_REAL_POS, 32'h7);
    // one general input at a time: seen in status, never clears
    for (int i = 0; i < 3; i++) begin
      gin <= 3'(1 << i);
      rd(OFS_DRV_STATUS, 32'h10 | (32'h200 << i), "gin_status");
      gin <= 3'h0;
      rd(OFS_REAL_POS, 32'h7, "real_kept");
    end
    enc.zset(1'b1);
    enc.zset(1'b0);
    rd(OFS_REAL_POS, 32'h0, "real_zclr");
    enc.zset(1'b1);
    wr(OFS_REAL_POS, 32'h5);
    rd(OFS_REAL_POS, 32'h5, "real_held");
    wr(OFS_COMMAND, {24'h0, CMD_EXT_MODE});
    rd(OFS_REAL_POS, 32'h0, "real_preactive");
    enc.zset(1'b0);
    wr(OFS_WDATA_LOW, 32'h0);
    wr(OFS_COMMAND, {24'h0, CMD_EXT_MODE});
  endtask
  task automatic t_zsrch;
    wr(OFS_DRIVE_PER, 32'h18);
    wr(OFS_COMMAND, {24'h0, CMD_ZSRCH_NEG});
    repeat (30) @(posedge clk_sys);
    check("zsrch_busy", 32'h1, {31'h0, drive_busy});
    enc.zset(1'b1);
    check("zsrch_stop", 32'h0, {30'h0, drive_busy, drive_neg_pulse});
    enc.zset(1'b0);
    wr(OFS_DRIVE_PER, 32'h14);
  endtask
  task automatic t_limit;
    int c = 0;
    wr(OFS_LIMIT_CFG, 32'h3);
    wr(OFS_CMP_UPPER, 32'h2);
    wr(OFS_LOGIC_POS, 32'h0);
    wr(OFS_COMMAND, {24'h0, CMD_DRV_POS});
    repeat (4) @(posedge clk_sys);
    do begin
      @(posedge clk_sys);
      c++;
    end while (drive_busy !== 1'b0 && c < 3000);
    check("busy_stop", 32'h0, {31'h0, drive_busy});
    rd(OFS_ERR_STATUS, 32'h1, "slim_err");
    wr(OFS_LOGIC_POS, 32'h0);
    rd(OFS_ERR_STATUS, 32'h0, "slim_clear");
  endtask
  task automatic t_ring;
    wr(OFS_WDATA_LOW, 32'h10);
    wr(OFS_COMMAND, {24'h0, CMD_EXT_MODE});
    wr(OFS_CMP_UPPER, 32'h9);
    wr(OFS_LOGIC_POS, 32'h8);
    drive(CMD_DRV_POS, 2);
    rd(OFS_LOGIC_POS, 32'h0, "ring_up");
    drive(CMD_DRV_NEG, 1);
    rd(OFS_LOGIC_POS, 32'h9, "ring_down");
    wr(OFS_CMP_LOWER, 32'h4);
    wr(OFS_REAL_POS, 32'h0);
    enc.step(1'b0);
    rd(OFS_REAL_POS, 32'h4, "ring_real");
    wr(OFS_LOGIC_POS, 32'h0);
    rd(OFS_ERR_STATUS, 32'h0, "ring_nolimit");
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    finish_test;
  end
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gin = 3'h0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr(OFS_INIT_PER, 32'h14);
    wr(OFS_DRIVE_PER, 32'h14);
    t_regs;
    t_count;
    t_cmp;
    t_enc;
    t_zclr;
    t_zsrch;
    t_limit;
    t_ring;
    finish_test;
  end
endmodule // tb_axis_position_compare_unit
